// ==== ptcr_chk.sv ====
/*
 * Concurrent checks on the signals joining the two ends.
 * Assumes it sits beside the interface, on the same CLK and NRST.
 */
`timescale 1ns/1ps
module ptcr_chk
    import ptcr_pkg::*;
#(
    parameter int BUS_W    = BUS_W_X4,
    parameter bit X4_BUILD = 1'b1
) (
    // Clock and reset
    input wire logic                         CLK,
    input wire logic                         NRST,
    // Credits
    input wire logic [NTYPE-1:0][HDR_W-1:0]  tx_hdr_credit_avail,
    input wire logic [NTYPE-1:0][DATA_W-1:0] tx_data_credit_avail,
    // Receive stream
    input wire logic [BUS_W-1:0]             rx_tlp_bus,
    input wire logic                         rx_tlp_valid,
    input wire logic                         rx_tlp_ready,
    input wire logic                         rx_tlp_first,
    input wire logic                         rx_tlp_last,
    input wire logic                         rx_upper_word_only,
    input wire logic                         rx_e2e_crc_fail,
    input wire logic                         rx_poisoned_flag,
    input wire logic                         rx_malformed_flag,
    // Credit return
    input wire logic [NTYPE-1:0]             data_credit_strobe
);
    // =========================================================================
    // Frame tracking: set after a taken beat that does not close the TLP
    logic in_frame_ff;
    logic nxt_in_frame;

    always_comb begin
        nxt_in_frame = in_frame_ff;
        if (!NRST) begin
            nxt_in_frame = 1'b0;
        end else if (rx_tlp_valid && rx_tlp_ready) begin
            nxt_in_frame = !rx_tlp_last;
        end
    end

    always_ff @(posedge CLK) begin
        in_frame_ff <= nxt_in_frame;
    end

    // =========================================================================
    // Assertions
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    frame_order_a: assert property (rx_tlp_valid |-> rx_tlp_first == !in_frame_ff)
        else $error("first flag out of frame order");
    first_gated_a: assert property (rx_tlp_first |-> rx_tlp_valid)
        else $error("first flag without valid beat");
    last_gated_a: assert property (rx_tlp_last |-> rx_tlp_valid)
        else $error("last flag without valid beat");
    upper_gated_a: assert property (rx_upper_word_only |-> rx_tlp_valid && X4_BUILD)
        else $error("upper word flag outside a four lane beat");
    err_gated_a: assert property (
        (rx_e2e_crc_fail || rx_poisoned_flag || rx_malformed_flag) |-> rx_tlp_valid)
        else $error("error flag without valid beat");
    beat_hold_a: assert property (
        rx_tlp_valid && !rx_tlp_ready |=> rx_tlp_valid
        && $stable(rx_tlp_bus) && $stable(rx_tlp_first) && $stable(rx_tlp_last))
        else $error("stalled beat changed");
    credit_reset_a: assert property (
        $rose(NRST) |-> tx_hdr_credit_avail == '0 && tx_data_credit_avail == '0)
        else $error("credits not cleared by reset");
    strobe_pulse_a: assert property (
        |data_credit_strobe |=> (data_credit_strobe & $past(data_credit_strobe)) == '0)
        else $error("data credit strobe longer than one cycle");

    cover property (rx_tlp_valid && rx_tlp_ready && rx_tlp_last);
    cover property (rx_tlp_valid && !rx_tlp_ready);
    cover property (|data_credit_strobe);
    cover property (tx_hdr_credit_avail[0][HDR_INF_BIT]);
endmodule

// ==== ptcr_core_end.sv ====
/*
 * Core end of the TLP credit and receive interface.
 * Assumes parsed link beats and UpdateFC events on CLK;
 * the lane strap is asynchronous.
 */
`timescale 1ns/1ps
module ptcr_core_end
    import ptcr_pkg::*;
#(
    parameter bit X4_BUILD    = 1'b1,
    parameter bit ECRC_EN     = 1'b1,
    parameter int BUS_W       = X4_BUILD ? BUS_W_X4 : BUS_W_X1,
    parameter int UPD_CYCLES  = UPD_TIMER_CYC,
    parameter int HDR_LIMIT   = HDR_THRESH,
    parameter int DATA_LIMIT  = DATA_THRESH
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              NRST,
    // User side
    ptcr_if.core                   UIF,
    // Link: received TLP beats
    input  wire logic [BUS_W-1:0]  LNK_RX_DATA,
    input  wire logic              LNK_RX_VALID,
    input  wire logic              LNK_RX_FIRST,
    input  wire logic              LNK_RX_LAST,
    input  wire logic              LNK_RX_UPPER_ONLY,
    input  wire logic              LNK_RX_CRC_BAD,
    input  wire logic              LNK_RX_EP,
    input  wire logic              LNK_RX_HAS_DATA,
    input  wire logic              LNK_RX_LEN_BAD,
    input  wire logic              LNK_RX_FMT_BAD,
    output logic                   LNK_RX_READY,
    // Link: received UpdateFC and transmitted TLPs
    input  wire logic              LNK_UPD_VALID,
    input  wire logic [1:0]        LNK_UPD_TYPE,
    input  wire logic [HDR_W-1:0]  LNK_UPD_HDR,
    input  wire logic [DATA_W-1:0] LNK_UPD_DATA,
    input  wire logic              LNK_TX_SENT,
    input  wire logic [1:0]        LNK_TX_TYPE,
    input  wire logic [DATA_W-2:0] LNK_TX_DCRED,
    // Link: UpdateFC requests to transmit
    output logic [2*NTYPE-1:0]     LNK_SEND_UPDFC,
    // Lane mapping
    input  wire logic              FLIP_LANES,
    output logic [LANES-1:0][1:0]  LANE_CHANNEL
);
    localparam int PW  = BUS_W + 7;
    localparam int TW  = $clog2(UPD_CYCLES + 1);

    // =========================================================================
    // Credit available tracking
    logic [NTYPE-1:0][HDR_W-1:0]  hca_ff, nxt_hca;
    logic [NTYPE-1:0][DATA_W-1:0] dca_ff, nxt_dca;

    always_comb begin
        nxt_hca = hca_ff;
        nxt_dca = dca_ff;
        for (int t = 0; t < NTYPE; t++) begin
            if (LNK_UPD_VALID && LNK_UPD_TYPE == 2'(t)) begin
                nxt_hca[t] = LNK_UPD_HDR;
                nxt_dca[t] = LNK_UPD_DATA;
            end else if (LNK_TX_SENT && LNK_TX_TYPE == 2'(t)) begin
                if (!hca_ff[t][HDR_INF_BIT] && hca_ff[t][HDR_INF_BIT-1:0] != '0)
                    nxt_hca[t] = hca_ff[t] - 1'b1;
                if (!dca_ff[t][DATA_INF_BIT]) begin
                    nxt_dca[t][DATA_INF_BIT-1:0] =
                        (dca_ff[t][DATA_INF_BIT-1:0] > LNK_TX_DCRED) ?
                        dca_ff[t][DATA_INF_BIT-1:0] - LNK_TX_DCRED : '0;
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            hca_ff <= '0;
            dca_ff <= '0;
        end else begin
            hca_ff <= nxt_hca;
            dca_ff <= nxt_dca;
        end
    end

    assign UIF.tx_hdr_credit_avail  = hca_ff;
    assign UIF.tx_data_credit_avail = dca_ff;

    // =========================================================================
    // Processed credit accumulation and UpdateFC scheduling
    logic [NTYPE-1:0][7:0]        hacc_ff, nxt_hacc;
    logic [NTYPE-1:0][DATA_W-1:0] dacc_ff, nxt_dacc;
    logic [TW-1:0]                tmr_ff, nxt_tmr;
    logic [2*NTYPE-1:0]           send_ff, nxt_send;
    logic                         expire;

    always_comb begin
        expire   = (tmr_ff == TW'(UPD_CYCLES - 1));
        nxt_tmr  = expire ? '0 : tmr_ff + 1'b1;
        nxt_hacc = hacc_ff;
        nxt_dacc = dacc_ff;
        nxt_send = '0;
        for (int t = 0; t < NTYPE; t++) begin
            if (UIF.hdr_credit_consumed[t])
                nxt_hacc[t] = hacc_ff[t] + 1'b1;
            if (UIF.data_credit_strobe[t])
                nxt_dacc[t] = dacc_ff[t] + DATA_W'(UIF.data_credit_count[t]);
            // Header types at even positions, data types at odd positions
            if (expire || UIF.user_buffer_full[2*t]
                    || hacc_ff[t] >= 8'(HDR_LIMIT)) begin
                nxt_send[2*t] = 1'b1;
                nxt_hacc[t]   = 8'(UIF.hdr_credit_consumed[t]);
            end
            if (expire || UIF.user_buffer_full[2*t+1]
                    || dacc_ff[t] >= DATA_W'(DATA_LIMIT)) begin
                nxt_send[2*t+1] = 1'b1;
                nxt_dacc[t]     = UIF.data_credit_strobe[t] ?
                                  DATA_W'(UIF.data_credit_count[t]) : '0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            hacc_ff <= '0;
            dacc_ff <= '0;
            tmr_ff  <= '0;
            send_ff <= '0;
        end else begin
            hacc_ff <= nxt_hacc;
            dacc_ff <= nxt_dacc;
            tmr_ff  <= nxt_tmr;
            send_ff <= nxt_send;
        end
    end

    assign LNK_SEND_UPDFC = send_ff;

    // =========================================================================
    // Receive path: beats buffered, flags travel with the data
    logic [PW-1:0] in_pkt, out_pkt;
    logic          out_valid;
    logic          malformed;

    assign malformed = LNK_RX_LEN_BAD || LNK_RX_FMT_BAD;
    assign in_pkt = {LNK_RX_DATA, LNK_RX_FIRST, LNK_RX_LAST,
                     X4_BUILD ? LNK_RX_UPPER_ONLY : 1'b0,
                     ECRC_EN ? LNK_RX_CRC_BAD : 1'b0,
                     LNK_RX_EP && LNK_RX_HAS_DATA,
                     malformed, 1'b0};

    ptcr_fifo #(
        .WIDTH (PW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .CLK       (CLK),
        .NRST      (NRST),
        .in_data   (in_pkt),
        .in_valid  (LNK_RX_VALID),
        .in_ready  (LNK_RX_READY),
        .out_data  (out_pkt),
        .out_valid (out_valid),
        .out_ready (UIF.rx_tlp_ready)
    );

    // Flags gated by valid to mark only real beats
    assign UIF.rx_tlp_valid       = out_valid;
    assign UIF.rx_tlp_bus         = out_pkt[PW-1:7];
    assign UIF.rx_tlp_first       = out_valid && out_pkt[6];
    assign UIF.rx_tlp_last        = out_valid && out_pkt[5];
    assign UIF.rx_upper_word_only = out_valid && out_pkt[4];
    assign UIF.rx_e2e_crc_fail    = out_valid && out_pkt[3];
    assign UIF.rx_poisoned_flag   = out_valid && out_pkt[2];
    assign UIF.rx_malformed_flag  = out_valid && out_pkt[1];

    // =========================================================================
    // Lane reversal strap: two-stage synchroniser, then mapping
    logic flip_s1_ff, flip_s2_ff;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            flip_s1_ff <= 1'b0;
            flip_s2_ff <= 1'b0;
        end else begin
            flip_s1_ff <= FLIP_LANES;
            flip_s2_ff <= flip_s1_ff;
        end
    end

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign LANE_CHANNEL[l] = flip_s2_ff ? 2'(LANES - 1 - l) : 2'(l);
    end
endmodule

// ==== ptcr_fifo.sv ====
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
module ptcr_fifo
    import ptcr_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             NRST,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0]      cnt_ff, nxt_cnt;
    logic             push, pop;

    // =========================================================================
    // Pointers
    always_comb begin
        in_ready  = (cnt_ff != (AW+1)'(DEPTH));
        out_valid = (cnt_ff != '0);
        out_data  = mem_ff[rd_ff];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        nxt_wr    = push ? ((wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1) : wr_ff;
        nxt_rd    = pop ? ((rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1) : rd_ff;
        nxt_cnt   = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // =========================================================================
    // Storage
    always_ff @(posedge CLK) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule

// ==== ptcr_if.sv ====
/*
 * Interface joining the core end and the user-logic end.
 * Assumes both ends share CLK.
 */
`timescale 1ns/1ps
interface ptcr_if
    import ptcr_pkg::*;
#(
    parameter int BUS_W = BUS_W_X4
) ();
    // Credits available toward the far receiver
    logic [NTYPE-1:0][HDR_W-1:0]  tx_hdr_credit_avail;
    logic [NTYPE-1:0][DATA_W-1:0] tx_data_credit_avail;
    // Receive TLP stream
    logic [BUS_W-1:0]             rx_tlp_bus;
    logic                         rx_tlp_valid;
    logic                         rx_tlp_ready;
    logic                         rx_tlp_first;
    logic                         rx_tlp_last;
    logic                         rx_upper_word_only;
    logic                         rx_e2e_crc_fail;
    logic                         rx_poisoned_flag;
    logic                         rx_malformed_flag;
    // Credit return
    logic [2*NTYPE-1:0]           user_buffer_full;
    logic [NTYPE-1:0]             hdr_credit_consumed;
    logic [NTYPE-1:0]             data_credit_strobe;
    logic [NTYPE-1:0][DCNT_W-1:0] data_credit_count;

    modport core (
        output tx_hdr_credit_avail, tx_data_credit_avail, rx_tlp_bus, rx_tlp_valid,
               rx_tlp_first, rx_tlp_last, rx_upper_word_only, rx_e2e_crc_fail,
               rx_poisoned_flag, rx_malformed_flag,
        input  rx_tlp_ready, user_buffer_full, hdr_credit_consumed,
               data_credit_strobe, data_credit_count
    );
    modport user (
        input  tx_hdr_credit_avail, tx_data_credit_avail, rx_tlp_bus, rx_tlp_valid,
               rx_tlp_first, rx_tlp_last, rx_upper_word_only, rx_e2e_crc_fail,
               rx_poisoned_flag, rx_malformed_flag,
        output rx_tlp_ready, user_buffer_full, hdr_credit_consumed,
               data_credit_strobe, data_credit_count
    );
endinterface

// ==== ptcr_pkg.sv ====
/*
 * Shared constants and types for the TLP credit and receive interface:
 * credit layouts, type indices, bus widths, timer counts.
 * Assumes a single 100 MHz clock domain for both ends.
 */
package ptcr_pkg;
    // =========================================================================
    // Credit layouts
    localparam int HDR_W          = 9;
    localparam int HDR_INF_BIT    = 8;
    localparam int DATA_W         = 13;
    localparam int DATA_INF_BIT   = 12;
    localparam int DCNT_W         = 8;
    localparam int NTYPE          = 3;
    localparam int TYPE_P         = 0;
    localparam int TYPE_NP        = 1;
    localparam int TYPE_CPL       = 2;
    // =========================================================================
    // Receive bus
    localparam int BUS_W_X4       = 64;
    localparam int BUS_W_X1       = 16;
    localparam int HALF_W_X4      = 32;
    localparam int LANES          = 4;
    // =========================================================================
    // Update timing
    localparam int CLK_MHZ        = 100;
    localparam int UPD_TIMER_NS   = 4000;
    localparam int UPD_TIMER_CYC  = UPD_TIMER_NS * CLK_MHZ / 1000;
    localparam int HDR_THRESH     = 8;
    localparam int DATA_THRESH    = 32;
    localparam int FIFO_DEPTH     = 8;
    // =========================================================================
    // Receive framing states
    typedef enum logic [1:0] {
        PTCR_IDLE = 2'h0,
        PTCR_BODY = 2'h1,
        PTCR_LAST = 2'h3
    } ptcr_rx_e;
endpackage

// ==== ptcr_user_end.sv ====
/*
 * User-logic end: consumes received TLP beats, returns credits.
 * Assumes the core end across the interface and a downstream consumer.
 */
`timescale 1ns/1ps
module ptcr_user_end
    import ptcr_pkg::*;
#(
    parameter int BUS_W = BUS_W_X4
) (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     NRST,
    // Core side
    ptcr_if.user                          CIF,
    // Consumer side
    output logic [BUS_W-1:0]              APP_DATA,
    output logic                          APP_VALID,
    output logic                          APP_FIRST,
    output logic                          APP_LAST,
    output logic                          APP_ERR,
    input  wire logic                     APP_READY,
    input  wire logic [2*NTYPE-1:0]       APP_BUF_FULL,
    // Credit return requests
    input  wire logic [NTYPE-1:0]         APP_HDR_DONE,
    input  wire logic [NTYPE-1:0]         APP_DATA_DONE,
    input  wire logic [NTYPE-1:0][7:0]    APP_DATA_NUM,
    // Credit view with infinite flag honoured
    output logic [NTYPE-1:0]              APP_HDR_OK,
    output logic [NTYPE-1:0]              APP_DATA_OK
);
    logic [BUS_W-1:0]             data_ff, nxt_data;
    logic                         val_ff, nxt_val, fst_ff, nxt_fst;
    logic                         lst_ff, nxt_lst, err_ff, nxt_err;
    logic [NTYPE-1:0]             dstb_ff, nxt_dstb;
    logic [NTYPE-1:0][7:0]        dnum_ff, nxt_dnum;
    ptcr_rx_e                     st_ff, nxt_st;
    logic                         take;

    // =========================================================================
    // Receive beat capture with frame tracking
    always_comb begin
        take     = CIF.rx_tlp_valid && (!val_ff || APP_READY);
        nxt_data = data_ff;
        nxt_fst  = fst_ff;
        nxt_lst  = lst_ff;
        nxt_err  = err_ff;
        nxt_val  = val_ff && !APP_READY;
        nxt_st   = st_ff;
        if (take) begin
            nxt_val  = 1'b1;
            nxt_data = CIF.rx_tlp_bus;
            nxt_fst  = CIF.rx_tlp_first;
            nxt_lst  = CIF.rx_tlp_last;
            nxt_err  = CIF.rx_e2e_crc_fail || CIF.rx_poisoned_flag
                       || CIF.rx_malformed_flag;
            case (st_ff)
                PTCR_IDLE: nxt_st = CIF.rx_tlp_last ? PTCR_LAST : PTCR_BODY;
                PTCR_BODY: nxt_st = CIF.rx_tlp_last ? PTCR_LAST : PTCR_BODY;
                PTCR_LAST: nxt_st = CIF.rx_tlp_last ? PTCR_LAST : PTCR_BODY;
                default:   nxt_st = PTCR_IDLE;
            endcase
        end
        // One-cycle data strobe with count held alongside
        nxt_dstb = APP_DATA_DONE & ~dstb_ff;
        nxt_dnum = APP_DATA_NUM;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            data_ff <= '0;
            val_ff  <= 1'b0;
            fst_ff  <= 1'b0;
            lst_ff  <= 1'b0;
            err_ff  <= 1'b0;
            st_ff   <= PTCR_IDLE;
            dstb_ff <= '0;
            dnum_ff <= '0;
        end else begin
            data_ff <= nxt_data;
            val_ff  <= nxt_val;
            fst_ff  <= nxt_fst;
            lst_ff  <= nxt_lst;
            err_ff  <= nxt_err;
            st_ff   <= nxt_st;
            dstb_ff <= nxt_dstb;
            dnum_ff <= nxt_dnum;
        end
    end

    assign CIF.rx_tlp_ready        = !val_ff || APP_READY;
    assign APP_DATA                = data_ff;
    assign APP_VALID               = val_ff;
    assign APP_FIRST               = fst_ff;
    assign APP_LAST                = lst_ff;
    assign APP_ERR                 = err_ff;
    assign CIF.user_buffer_full    = APP_BUF_FULL;
    assign CIF.hdr_credit_consumed = APP_HDR_DONE;
    assign CIF.data_credit_strobe  = dstb_ff;
    assign CIF.data_credit_count   = dnum_ff;

    // =========================================================================
    // Credit sufficiency, count ignored while infinite
    for (genvar t = 0; t < NTYPE; t++) begin : g_ok
        assign APP_HDR_OK[t]  = CIF.tx_hdr_credit_avail[t][HDR_INF_BIT]
                              || CIF.tx_hdr_credit_avail[t][HDR_INF_BIT-1:0] != '0;
        assign APP_DATA_OK[t] = CIF.tx_data_credit_avail[t][DATA_INF_BIT]
                              || CIF.tx_data_credit_avail[t][DATA_INF_BIT-1:0] != '0;
    end
endmodule

// ==== tb_top.sv ====
/*
 * Testbench: both ends joined by the interface, link and consumer sides driven here.
 * Assumes all block files are compiled first.
 */
`timescale 1ns/1ps
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch at %0t: %s", $time, m); end end
module tb_top import ptcr_pkg::*;;
    // =========================================================================
    // Signals
    logic             CLK = 1'b0, NRST = 1'b0;
    logic [63:0]      lnk_data = '0;
    logic             lnk_valid = 0, lnk_first = 0, lnk_last = 0, lnk_upper = 0;
    logic             lnk_crc = 0, lnk_ep = 0, lnk_hasd = 0, lnk_lenb = 0, lnk_fmtb = 0;
    logic             lnk_ready, upd_valid = 0, tx_sent = 0, flip = 0, app_ready = 0;
    logic [1:0]       upd_type = '0, tx_type = '0;
    logic [8:0]       upd_hdr = '0;
    logic [12:0]      upd_data = '0;
    logic [11:0]      tx_dcred = '0;
    logic [5:0]       send_updfc, app_buf_full = '0;
    logic [3:0][1:0]  lane_ch;
    logic [2:0]       app_hdr_done = '0, app_data_done = '0, app_hdr_ok, app_data_ok;
    logic [2:0][7:0]  app_data_num = '0;
    logic [67:0]      app_beat;
    logic [69:0]      got [$];
    int               num_errors = 0, tests_run = 0, n, k;
    int               cnt [6];

    ptcr_if #(.BUS_W(BUS_W_X4)) cif ();
    ptcr_core_end #(.UPD_CYCLES(400)) ptcr_core_end_inst (
        .CLK, .NRST, .UIF(cif), .LNK_RX_DATA(lnk_data), .LNK_RX_VALID(lnk_valid),
        .LNK_RX_FIRST(lnk_first), .LNK_RX_LAST(lnk_last), .LNK_RX_UPPER_ONLY(lnk_upper),
        .LNK_RX_CRC_BAD(lnk_crc), .LNK_RX_EP(lnk_ep), .LNK_RX_HAS_DATA(lnk_hasd),
        .LNK_RX_LEN_BAD(lnk_lenb), .LNK_RX_FMT_BAD(lnk_fmtb), .LNK_RX_READY(lnk_ready),
        .LNK_UPD_VALID(upd_valid), .LNK_UPD_TYPE(upd_type), .LNK_UPD_HDR(upd_hdr),
        .LNK_UPD_DATA(upd_data), .LNK_TX_SENT(tx_sent), .LNK_TX_TYPE(tx_type),
        .LNK_TX_DCRED(tx_dcred), .LNK_SEND_UPDFC(send_updfc), .FLIP_LANES(flip),
        .LANE_CHANNEL(lane_ch));
    ptcr_user_end ptcr_user_end_inst (
        .CLK, .NRST, .CIF(cif), .APP_DATA(app_beat[67:4]), .APP_VALID(app_beat[3]),
        .APP_FIRST(app_beat[2]), .APP_LAST(app_beat[1]), .APP_ERR(app_beat[0]),
        .APP_READY(app_ready), .APP_BUF_FULL(app_buf_full),
        .APP_HDR_DONE(app_hdr_done), .APP_DATA_DONE(app_data_done),
        .APP_DATA_NUM(app_data_num), .APP_HDR_OK(app_hdr_ok), .APP_DATA_OK(app_data_ok));
    ptcr_chk #(.BUS_W(BUS_W_X4)) ptcr_chk_inst (
        .CLK, .NRST, .tx_hdr_credit_avail(cif.tx_hdr_credit_avail),
        .tx_data_credit_avail(cif.tx_data_credit_avail), .rx_tlp_bus(cif.rx_tlp_bus),
        .rx_tlp_valid(cif.rx_tlp_valid), .rx_tlp_ready(cif.rx_tlp_ready),
        .rx_tlp_first(cif.rx_tlp_first), .rx_tlp_last(cif.rx_tlp_last),
        .rx_upper_word_only(cif.rx_upper_word_only), .rx_e2e_crc_fail(cif.rx_e2e_crc_fail),
        .rx_poisoned_flag(cif.rx_poisoned_flag), .rx_malformed_flag(cif.rx_malformed_flag),
        .data_credit_strobe(cif.data_credit_strobe));

    always #5 CLK = ~CLK;

    // =========================================================================
    // Monitor: UpdateFC pulses per bit and beats taken by the user end
    always @(negedge CLK) begin
        for (int b = 0; b < 6; b++) if (send_updfc[b] === 1'b1) cnt[b]++;
        if (cif.rx_tlp_valid && cif.rx_tlp_ready) got.push_back({cif.rx_tlp_bus,
            cif.rx_tlp_first, cif.rx_tlp_last, cif.rx_upper_word_only,
            cif.rx_e2e_crc_fail, cif.rx_poisoned_flag, cif.rx_malformed_flag});
    end

    // =========================================================================
    // Tasks
    task step;
        @(posedge CLK);
        #1;
    endtask

    task put_beat(input int i);
        lnk_data = 64'hA500_0000_0000_0000 | 64'(i);
        lnk_first = i % 3 == 0;
        lnk_last = i % 3 == 2;
        lnk_upper = i == 6;
        lnk_crc = i == 2;
        lnk_ep = i < 2;
        lnk_hasd = i == 0 || i == 3;
        lnk_lenb = i == 4;
        lnk_fmtb = i == 5;
    endtask

    function automatic logic [69:0] beat_exp(input int i);
        return {64'hA500_0000_0000_0000 | 64'(i), i % 3 == 0, i % 3 == 2, i == 6, i == 2,
                i == 0, i == 4 || i == 5};
    endfunction

    task wait_timer(output int c);
        for (c = 0; c < 1000; c++) begin
            step;
            if (send_updfc === 6'h3F) break;
        end
    endtask

    task summarize;
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        #60000;
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize;
    end

    // =========================================================================
    // Tests
    initial begin
        repeat (3) @(posedge CLK);
        #1;
        NRST = 1'b1;
        `CHK(lane_ch, 8'hE4, "straight lanes")
        for (int t = 0; t < NTYPE; t++) begin
            upd_valid = 1'b1;
            upd_type = 2'(t);
            tx_type = 2'(t);
            upd_hdr = 9'h005;
            upd_data = 13'h0020;
            step;
            upd_valid = 1'b0;
            tx_sent = 1'b1;
            tx_dcred = 12'h003;
            step;
            tx_sent = 1'b0;
            `CHK(cif.tx_hdr_credit_avail[t], 9'h004, "hdr credit")
            `CHK(cif.tx_data_credit_avail[t], 13'h001D, "data credit")
            upd_valid = 1'b1;
            upd_hdr = 9'h100;
            upd_data = 13'h1000;
            tx_sent = 1'b1;
            step;
            upd_valid = 1'b0;
            step;
            tx_sent = 1'b0;
            `CHK(cif.tx_hdr_credit_avail[t], 9'h100, "infinite hdr")
            `CHK(cif.tx_data_credit_avail[t], 13'h1000, "infinite data")
            `CHK({app_hdr_ok[t], app_data_ok[t]}, 2'b11, "credit view")
        end
        $display("test credits done");
        n = 0;
        while (n < 12) begin
            put_beat(n);
            lnk_valid = 1'b1;
            k = lnk_ready;
            step;
            if (k == 0) break;
            n++;
        end
        lnk_valid = 1'b0;
        `CHK(n, FIFO_DEPTH + 1, "fill depth")
        `CHK(app_beat, {8'hA5, 60'hD}, "held beat")
        app_ready = 1'b1;
        repeat (24) step;
        `CHK(got.size(), n, "beat count")
        for (int i = 0; i < n; i++)
            `CHK(got[i], beat_exp(i), "beat")
        $display("test receive done");
        wait_timer(k);
        wait_timer(k);
        `CHK(k + 1, 400, "timer period")
        step;
        cnt = '{default: 0};
        app_hdr_done = 3'b010;
        repeat (7) step;
        app_hdr_done = 3'b000;
        repeat (5) step;
        `CHK(cnt[2], 0, "hdr early update")
        app_hdr_done = 3'b010;
        step;
        app_hdr_done = 3'b000;
        repeat (5) step;
        `CHK(cnt[2], 1, "hdr update")
        app_data_num[2] = 8'h14;
        app_data_done = 3'b100;
        repeat (2) step;
        app_data_done = 3'b000;
        app_data_num[2] = 8'hFF;
        repeat (6) step;
        `CHK(cnt[5], 0, "data early update")
        app_data_num[2] = 8'h0C;
        app_data_done = 3'b100;
        step;
        app_data_done = 3'b000;
        repeat (6) step;
        `CHK(cnt[5], 1, "data update")
        cnt = '{default: 0};
        app_buf_full = 6'h08;
        repeat (3) step;
        app_buf_full = 6'h00;
        repeat (5) step;
        `CHK(cnt[3], 3, "full updates")
        $display("test update done");
        flip = 1'b1;
        repeat (4) step;
        `CHK(lane_ch, 8'h1B, "reversed lanes")
        $display("test lanes done");
        summarize;
    end
endmodule
